/* File: include/sfct_consts.svh */
// Constants for the serial flash command and timing sequencer.
// Assumes a 20 MHz system clock and a slow external serial link.
// Contract
// - Serial input captured on rising clock edge.
// - Idle-low and idle-high clock both accepted.
// - Opcode then 24 address bits, MSB first.
// - Status read skips the address framing.
// - Opcodes 68H and E8H read array continuously.
// - Opcode 52H reads a main array page.
// - 54H/56H/D4H/D6H read first or second buffer.
// - Opcode D7H reads status.
// - Page-buffer transfer or compare within 250 us.
// - Erase+program 20 ms, program 14, erase 8.
// - Busy output low within 200 ns.
// - Sector decoded from page address high bits.
`ifndef SFCT_CONSTS_SVH
`define SFCT_CONSTS_SVH

// ==============================================================
// Clock and timing figures
`define SFCT_CLK_HZ 20000000
`define SFCT_T_XFR_US 250
`define SFCT_T_EP_MS 20
`define SFCT_T_P_MS 14
`define SFCT_T_PE_MS 8
`define SFCT_T_BE_MS 12
`define SFCT_T_CSB_NS 200
// Longest times round down to whole cycles
`define SFCT_XFR_CYC (`SFCT_T_XFR_US * (`SFCT_CLK_HZ / 1000000))
`define SFCT_EP_CYC (`SFCT_T_EP_MS * (`SFCT_CLK_HZ / 1000))
`define SFCT_P_CYC (`SFCT_T_P_MS * (`SFCT_CLK_HZ / 1000))
`define SFCT_PE_CYC (`SFCT_T_PE_MS * (`SFCT_CLK_HZ / 1000))
`define SFCT_BE_CYC (`SFCT_T_BE_MS * (`SFCT_CLK_HZ / 1000))
`define SFCT_CSB_CYC (`SFCT_T_CSB_NS / (1000000000 / `SFCT_CLK_HZ))

// ==============================================================
// Framing
`define SFCT_OPC_BITS 8
`define SFCT_ADDR_BITS 24
`define SFCT_PAGE_LSB 9
`define SFCT_PAGE_W 11
`define SFCT_OFFS_W 9

// ==============================================================
// Opcodes
`define SFCT_OP_CAR_LEG 8'h68
`define SFCT_OP_CAR 8'he8
`define SFCT_OP_PAGE_RD 8'h52
`define SFCT_OP_PAGE_RD_M 8'hd2
`define SFCT_OP_BUF1_LEG 8'h54
`define SFCT_OP_BUF2_LEG 8'h56
`define SFCT_OP_BUF1_RD 8'hd4
`define SFCT_OP_BUF2_RD 8'hd6
`define SFCT_OP_STATUS 8'hd7
`define SFCT_OP_STATUS_LEG 8'h57
`define SFCT_OP_XFR1 8'h53
`define SFCT_OP_XFR2 8'h55
`define SFCT_OP_CMP1 8'h60
`define SFCT_OP_CMP2 8'h61
`define SFCT_OP_PE1 8'h83
`define SFCT_OP_PE2 8'h86
`define SFCT_OP_PN1 8'h88
`define SFCT_OP_PN2 8'h89
`define SFCT_OP_PGE 8'h81
`define SFCT_OP_BLKE 8'h50
`define SFCT_OP_THRU1 8'h82
`define SFCT_OP_THRU2 8'h85
`define SFCT_OP_RW1 8'h58
`define SFCT_OP_RW2 8'h59

`endif

/* File: include/sfct_pkg.sv */
// Types shared by the serial flash sequencer files.
// Assumes sfct_consts.svh is on the include path.
package sfct_pkg;
    // ==============================================================
    // Decoded command classes
    typedef enum logic [3:0] {
        SFCT_CMD_NONE,
        SFCT_CMD_CAR,
        SFCT_CMD_PAGE_RD,
        SFCT_CMD_BUF1_RD,
        SFCT_CMD_BUF2_RD,
        SFCT_CMD_STATUS,
        SFCT_CMD_XFR,
        SFCT_CMD_ERPRG,
        SFCT_CMD_PRG,
        SFCT_CMD_ERASE,
        SFCT_CMD_BLKE
    } sfct_cmd_t;
    // Sector number
    typedef logic [2:0] sfct_sector_t;
endpackage

/* File: rtl/sfct_core.sv */
// Command framing and timing core of a serial page flash memory.
// Assumes sck, cs_n, si and reset_n come from pins off the sys_clk domain.
`timescale 1ns/1ps
`default_nettype none
`include "sfct_consts.svh"
module sfct_core #(
    parameter int XFR_CYC = `SFCT_XFR_CYC,
    parameter int EP_CYC = `SFCT_EP_CYC,
    parameter int P_CYC = `SFCT_P_CYC,
    parameter int PE_CYC = `SFCT_PE_CYC,
    parameter int BE_CYC = `SFCT_BE_CYC
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic reset_n,
    input wire logic [7:0] rd_data,
    output logic so,
    output logic so_oe,
    output logic rdy_busy_n,
    output sfct_pkg::sfct_cmd_t cmd,
    output logic cmd_valid,
    output logic cmd_rejected,
    output logic [`SFCT_PAGE_W-1:0] page_select_bits,
    output logic [`SFCT_OFFS_W-1:0] byte_offset_bits,
    output sfct_pkg::sfct_sector_t sector,
    output logic rd_strobe
);
    import sfct_pkg::*;

    // ==============================================================
    // Pin synchronisers
    logic cs_s1_reg, sck_s1_reg, si_s1_reg, rs_s1_reg; // First stage
    logic cs_s_reg, sck_s_reg, si_s_reg, rs_s_reg; // Second stage
    logic sck_d_reg; // Previous synced clock for edge finding

    // Two flops per pin; only the second stage is read
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            // Select starts deselected so no false select edge follows
            cs_s1_reg <= 1'b1;
            sck_s1_reg <= 1'b0;
            si_s1_reg <= 1'b0;
            rs_s1_reg <= 1'b0;
            cs_s_reg <= 1'b1;
            sck_s_reg <= 1'b0;
            si_s_reg <= 1'b0;
            rs_s_reg <= 1'b0;
            sck_d_reg <= 1'b0;
        end else begin
            cs_s1_reg <= cs_n;
            sck_s1_reg <= sck;
            si_s1_reg <= si;
            rs_s1_reg <= reset_n;
            cs_s_reg <= cs_s1_reg;
            sck_s_reg <= sck_s1_reg;
            si_s_reg <= si_s1_reg;
            rs_s_reg <= rs_s1_reg;
            sck_d_reg <= sck_s_reg;
        end
    end

    // ==============================================================
    // Edge and frame decode
    // Idle level of sck at select fall is irrelevant: a rising edge
    // seen only while selected counts, so either idle form works
    wire selected = !cs_s_reg && rs_s_reg;
    wire sck_rise = selected && sck_s_reg && !sck_d_reg;
    wire sck_fall = selected && !sck_s_reg && sck_d_reg;
    logic cs_d_reg; // Previous synced select
    wire cs_rise = cs_s_reg && !cs_d_reg;

    // ==============================================================
    // Shift register and bit count
    logic [31:0] sh_reg; // Opcode and address, MSB first
    logic [5:0] bits_reg; // Bits taken this frame
    logic [2:0] obit_reg; // Output bit index
    logic [7:0] obyte_reg; // Byte being shifted out
    logic [31:0] sh_next;
    assign sh_next = {sh_reg[30:0], si_s_reg};

    // Decode an opcode into a command class
    function automatic sfct_cmd_t decode(input logic [7:0] op);
        unique case (op)
            `SFCT_OP_CAR_LEG, `SFCT_OP_CAR: decode = SFCT_CMD_CAR;
            `SFCT_OP_PAGE_RD,
            `SFCT_OP_PAGE_RD_M: decode = SFCT_CMD_PAGE_RD;
            `SFCT_OP_BUF1_LEG,
            `SFCT_OP_BUF1_RD: decode = SFCT_CMD_BUF1_RD;
            `SFCT_OP_BUF2_LEG,
            `SFCT_OP_BUF2_RD: decode = SFCT_CMD_BUF2_RD;
            `SFCT_OP_STATUS,
            `SFCT_OP_STATUS_LEG: decode = SFCT_CMD_STATUS;
            `SFCT_OP_XFR1, `SFCT_OP_XFR2, `SFCT_OP_CMP1, `SFCT_OP_CMP2,
            `SFCT_OP_RW1, `SFCT_OP_RW2: decode = SFCT_CMD_XFR;
            // Direct program and buffer program both self-time
            `SFCT_OP_PE1, `SFCT_OP_PE2, `SFCT_OP_THRU1,
            `SFCT_OP_THRU2: decode = SFCT_CMD_ERPRG;
            `SFCT_OP_PN1, `SFCT_OP_PN2: decode = SFCT_CMD_PRG;
            `SFCT_OP_PGE: decode = SFCT_CMD_ERASE;
            `SFCT_OP_BLKE: decode = SFCT_CMD_BLKE;
            default: decode = SFCT_CMD_NONE;
        endcase
    endfunction

    // Sector from the 11 page bits
    function automatic sfct_sector_t sect(input logic [10:0] pa);
        if (pa[10:3] == 8'h00) sect = 3'h0;
        else if (pa[10:8] == 3'h0) sect = 3'h1;
        else if (pa[10:8] == 3'h1) sect = 3'h2;
        else if (pa[10:9] == 2'h1) sect = 3'h3;
        else if (pa[10:9] == 2'h2) sect = 3'h4;
        else sect = 3'h5;
    endfunction

    wire sfct_cmd_t op_class = decode(sh_reg[7:0]);
    wire op_done = bits_reg == 6'(`SFCT_OPC_BITS);
    // Status read answers right after the opcode, no address
    wire is_status = op_class == SFCT_CMD_STATUS;
    // Opcode of a full frame sits in the top byte once 32 bits are in
    wire sfct_cmd_t frame_class = decode(sh_reg[31:24]);
    wire is_self_timed = frame_class inside {SFCT_CMD_XFR, SFCT_CMD_ERPRG,
        SFCT_CMD_PRG, SFCT_CMD_ERASE, SFCT_CMD_BLKE};
    wire addr_done = bits_reg == 6'(`SFCT_OPC_BITS + `SFCT_ADDR_BITS);

    // ==============================================================
    // Operation timer
    logic tmr_busy, tmr_done, tmr_load;
    logic [18:0] tmr_cyc;
    // Longest-allowed durations per operation
    // Busy also covers the load cycle, so the timer runs one short
    // and the busy spell never exceeds the longest allowed time
    assign tmr_cyc = (cmd == SFCT_CMD_XFR) ? 19'(XFR_CYC - 1) :
        (cmd == SFCT_CMD_ERPRG) ? 19'(EP_CYC - 1) :
        (cmd == SFCT_CMD_PRG) ? 19'(P_CYC - 1) :
        (cmd == SFCT_CMD_ERASE) ? 19'(PE_CYC - 1) : 19'(BE_CYC - 1);
    logic armed_reg; // Self-timed command framed, waits for select rise
    assign tmr_load = cs_rise && armed_reg;
    sfct_op_timer #(.CNT_W(19)) u_timer (
        .sys_clk(sys_clk),
        .rst(rst),
        .load(tmr_load),
        .cycles(tmr_cyc),
        .busy(tmr_busy),
        .done(tmr_done)
    );

    // Frame capture; array commands during busy are refused
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cs_d_reg <= 1'b1;
            sh_reg <= 32'h0;
            bits_reg <= 6'h0;
            cmd <= SFCT_CMD_NONE;
            cmd_valid <= 1'b0;
            cmd_rejected <= 1'b0;
            armed_reg <= 1'b0;
            page_select_bits <= '0;
            byte_offset_bits <= '0;
            sector <= 3'h0;
        end else begin
            cs_d_reg <= cs_s_reg;
            cmd_valid <= 1'b0;
            cmd_rejected <= 1'b0;
            if (!selected) begin
                bits_reg <= 6'h0;
                if (cs_rise) armed_reg <= 1'b0;
            end else if (sck_rise && bits_reg != 6'h3f) begin
                sh_reg <= sh_next;
                bits_reg <= bits_reg + 6'h1;
            end else if (op_done && is_status) begin
                cmd <= SFCT_CMD_STATUS;
                cmd_valid <= 1'b1;
                bits_reg <= 6'h3f;
            end else if (addr_done) begin
                bits_reg <= 6'h3f;
                cmd <= frame_class;
                page_select_bits <= sh_reg[`SFCT_PAGE_LSB +: `SFCT_PAGE_W];
                byte_offset_bits <= sh_reg[`SFCT_OFFS_W-1:0];
                sector <= sect(sh_reg[`SFCT_PAGE_LSB +: `SFCT_PAGE_W]);
                if (tmr_busy && frame_class != SFCT_CMD_STATUS) begin
                    cmd_rejected <= 1'b1;
                end else begin
                    cmd_valid <= 1'b1;
                    armed_reg <= is_self_timed;
                end
            end
        end
    end

    // ==============================================================
    // Read output shifter
    wire is_self_timed_cmd = cmd inside {SFCT_CMD_XFR, SFCT_CMD_ERPRG,
        SFCT_CMD_PRG, SFCT_CMD_ERASE, SFCT_CMD_BLKE, SFCT_CMD_NONE};
    wire reading = cmd_valid && !is_self_timed_cmd;
    logic out_on_reg; // Output phase of a read frame
    // Status byte: ready flag in bit 7, rest zero
    wire [7:0] byte_src = (cmd == SFCT_CMD_STATUS) ?
        {!tmr_busy, 7'h0} : rd_data;

    // Bits change on falling clock so the host samples on rising
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            out_on_reg <= 1'b0;
            obit_reg <= 3'h7;
            obyte_reg <= 8'h0;
            so <= 1'b0;
            so_oe <= 1'b0;
            rd_strobe <= 1'b0;
        end else begin
            rd_strobe <= 1'b0;
            so_oe <= out_on_reg && selected;
            if (!selected) begin
                out_on_reg <= 1'b0;
                obit_reg <= 3'h7;
            end else if (reading) begin
                out_on_reg <= 1'b1;
                obyte_reg <= byte_src;
                rd_strobe <= 1'b1;
            end else if (out_on_reg && sck_fall) begin
                so <= obyte_reg[obit_reg];
                obit_reg <= obit_reg - 3'h1;
                if (obit_reg == 3'h0) begin
                    obyte_reg <= byte_src;
                    rd_strobe <= 1'b1;
                end
            end
        end
    end

    // Busy drops one cycle after synced select rise, far under 200 ns
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rdy_busy_n <= 1'b1;
        end else begin
            rdy_busy_n <= !(tmr_busy || tmr_load) || tmr_done;
        end
    end
endmodule
`default_nettype wire

/* File: rtl/sfct_op_timer.sv */
// Self-timed operation timer for the serial flash sequencer.
// Assumes a load pulse with a nonzero cycle count on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module sfct_op_timer #(
    parameter int CNT_W = 19
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic load,
    input wire logic [CNT_W-1:0] cycles,
    output logic busy,
    output logic done
);
    // ==============================================================
    // Down counter
    logic [CNT_W-1:0] cnt_reg; // Cycles left
    logic busy_reg; // Operation running
    logic done_reg; // One-cycle finish pulse
    wire last = busy_reg && (cnt_reg == {{(CNT_W-1){1'b0}}, 1'b1});

    // Count down; a load while running is refused upstream
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= '0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            done_reg <= last;
            if (load && !busy_reg) begin
                cnt_reg <= cycles;
                busy_reg <= 1'b1;
            end else if (last) begin
                busy_reg <= 1'b0;
                cnt_reg <= '0;
            end else if (busy_reg) begin
                cnt_reg <= cnt_reg - CNT_W'(1);
            end
        end
    end
    assign busy = busy_reg;
    assign done = done_reg;
endmodule
`default_nettype wire

/* File: tb/sfct_core_chk.sv */
// Checker for the serial flash command core, bound onto sfct_core.
// Assumes it sees only that module's ports, all on sys_clk.
`timescale 1ns/1ps
`default_nettype none
`include "sfct_consts.svh"
module sfct_core_chk
    import sfct_pkg::*;
#(
    parameter int XFR_CYC = 50,
    parameter int EP_CYC = 400,
    parameter int P_CYC = 280,
    parameter int PE_CYC = 160,
    parameter int BE_CYC = 240
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic so_oe,
    input wire logic rdy_busy_n,
    input wire sfct_pkg::sfct_cmd_t cmd,
    input wire logic cmd_valid,
    input wire logic cmd_rejected,
    input wire logic [`SFCT_PAGE_W-1:0] page_select_bits,
    input wire logic [`SFCT_OFFS_W-1:0] byte_offset_bits,
    input wire sfct_pkg::sfct_sector_t sector
);
    // ==========================================================
    // Helper state: bits seen on the wire and busy bookkeeping
    logic [31:0] sh;
    logic [5:0] nb;
    logic vq, cs_q, pend;
    int bcnt, lim;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Read opcodes only; others are left to other checks
    function automatic sfct_cmd_t dec(input logic [7:0] op);
        case (op)
            8'h68, 8'he8: return SFCT_CMD_CAR;
            8'h52: return SFCT_CMD_PAGE_RD;
            8'h54, 8'hd4: return SFCT_CMD_BUF1_RD;
            8'h56, 8'hd6: return SFCT_CMD_BUF2_RD;
            default: return SFCT_CMD_NONE;
        endcase
    endfunction
    function automatic sfct_sector_t sec(input logic [10:0] p);
        if (p[10:3] == 8'h00) return 3'h0;
        if (p[10:9] == 2'h0) return 3'h1 + {2'h0, p[8]};
        return {1'b0, p[10:9]} + 3'h2;
    endfunction
    // Longest legal busy spell per command class, 0 if untimed
    function automatic int tmax(input sfct_cmd_t c);
        case (c)
            SFCT_CMD_XFR: return XFR_CYC;
            SFCT_CMD_ERPRG: return EP_CYC;
            SFCT_CMD_PRG: return P_CYC;
            SFCT_CMD_ERASE: return PE_CYC;
            SFCT_CMD_BLKE: return BE_CYC;
            default: return 0;
        endcase
    endfunction
    // Shift si on raw clock rises; limit is frozen once busy
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sh <= 32'h0;
            nb <= 6'h0;
            vq <= 1'b0;
            cs_q <= 1'b1;
            pend <= 1'b0;
            bcnt <= 0;
            lim <= 0;
        end else begin
            cs_q <= cs_n;
            vq <= cmd_valid;
            bcnt <= rdy_busy_n ? 0 : bcnt + 1;
            if (rdy_busy_n) lim <= tmax(cmd);
            if (cs_n) begin
                nb <= 6'h0;
            end else if ($rose(sck)) begin
                sh <= {sh[30:0], si};
                nb <= nb + 6'h1;
            end
            if (cs_n && !cs_q) pend <= 1'b0;
            else if (vq && tmax(cmd) != 0) pend <= 1'b1;
        end
    end
    // ==========================================================
    // Assertions
    sequence busy_s;
        ##[1:5] !rdy_busy_n;
    endsequence
    busy_start_a: assert property ($rose(cs_n) && pend |-> busy_s)
        else $error("busy not shown soon after select release");
    busy_len_a: assert property ($rose(rdy_busy_n) |->
        bcnt <= lim && bcnt + 8 >= lim) else $error("busy length wrong");
    frame_len_a: assert property (cmd_valid |-> nb == 6'd32 ||
        (nb == 6'd8 && sh[7:0] == 8'hd7)) else $error("bad frame length");
    rd_decode_a: assert property (cmd_valid && nb == 6'd32 &&
        dec(sh[31:24]) != SFCT_CMD_NONE |=> cmd == dec(sh[31:24]))
        else $error("read opcode decoded wrongly");
    status_decode_a: assert property (cmd_valid && nb == 6'd8
        |=> cmd == SFCT_CMD_STATUS) else $error("status not decoded");
    addr_fields_a: assert property (cmd_valid && nb == 6'd32 |=>
        page_select_bits == sh[19:9] && byte_offset_bits == sh[8:0])
        else $error("address fields wrong");
    sector_map_a: assert property (cmd_valid |->
        ##2 sector == sec(page_select_bits)) else $error("sector wrong");
    busy_refuse_a: assert property (cmd_rejected |-> !rdy_busy_n)
        else $error("refusal while ready");
    busy_accept_a: assert property (cmd_valid && !rdy_busy_n |=>
        cmd == SFCT_CMD_STATUS) else $error("array command taken while busy");
    oe_start_a: assert property ($rose(so_oe) |-> $past(cmd_valid, 2))
        else $error("output enabled without a framed command");
endmodule
bind sfct_core sfct_core_chk #(.XFR_CYC(XFR_CYC), .EP_CYC(EP_CYC),
    .P_CYC(P_CYC), .PE_CYC(PE_CYC), .BE_CYC(BE_CYC)) sfct_core_chk_i (
    .sys_clk, .rst, .cs_n, .sck, .si, .so_oe, .rdy_busy_n, .cmd,
    .cmd_valid, .cmd_rejected, .page_select_bits, .byte_offset_bits,
    .sector);
`default_nettype wire

/* File: tb/sfct_host_model.sv */
// Serial host model: drives select, clock and data into the core.
// Assumes the bench calls its tasks; link edges step off sys_clk.
`timescale 1ns/1ps
`default_nettype none
module sfct_host_model #(
    parameter int WAIT_CYC = 40
) (
    input wire logic sys_clk,
    input wire logic so,
    output logic cs_n,
    output logic sck,
    output logic si
);
    // Select is high from time zero, before reset_n lets go
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #3;
    endtask
    // Power-up settling, scaled down to keep the run short
    task automatic settle();
        tick(WAIT_CYC);
    endtask
    // n bits out MSB first, then r bits taken from so before each rise
    task automatic frame(input logic [31:0] w, input int n,
                         input logic m3, input int r,
                         output logic [31:0] rd);
        rd = 32'h0;
        sck = m3;
        tick(1);
        cs_n = 1'b0;
        tick(8);
        for (int i = 0; i < n + r; i++) begin
            sck = 1'b0;
            si = (i < n) ? w[n-1-i] : ~si;
            tick(5);
            if (i >= n) rd = {rd[30:0], so};
            sck = 1'b1;
            tick(3);
        end
        sck = m3;
        tick(8);
        cs_n = 1'b1;
        // Released data line must not look like a held bit
        si = ~si;
        tick(8);
    endtask
endmodule
`default_nettype wire

/* File: tb/test_serial_flash_command_timing.sv */
// Self-checking bench for the serial flash command core.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fail_count++; \
    $display("Error t=%0t got %h exp %h", $time, a, b); end end
module test_serial_flash_command_timing;
    import sfct_pkg::*;
    localparam logic [7:0] ROP [8] = '{8'h68, 8'he8, 8'h52, 8'h54, 8'h56,
        8'hd4, 8'hd6, 8'hd2};
    localparam sfct_cmd_t RCL [8] = '{SFCT_CMD_CAR, SFCT_CMD_CAR,
        SFCT_CMD_PAGE_RD, SFCT_CMD_BUF1_RD, SFCT_CMD_BUF2_RD,
        SFCT_CMD_BUF1_RD, SFCT_CMD_BUF2_RD, SFCT_CMD_PAGE_RD};
    localparam logic [10:0] EPG [4] = '{11'h007, 11'h008, 11'h0ff, 11'h100};
    localparam logic [7:0] TOP [5] = '{8'h53, 8'h83, 8'h88, 8'h81, 8'h50};
    localparam sfct_cmd_t TCL [5] = '{SFCT_CMD_XFR, SFCT_CMD_ERPRG,
        SFCT_CMD_PRG, SFCT_CMD_ERASE, SFCT_CMD_BLKE};
    localparam int TLIM [5] = '{50, 400, 280, 160, 240};
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic reset_n = 1'b0;
    logic [7:0] rd_data = 8'h00;
    logic cs_n, sck, si, so, so_oe, rdy_busy_n, cmd_valid, cmd_rejected;
    logic rd_strobe;
    sfct_cmd_t cmd;
    logic [10:0] page_select_bits, pg;
    logic [8:0] byte_offset_bits, off;
    sfct_sector_t sector;
    logic [31:0] rd;
    int fail_count = 0;
    int checked = 0;
    int seed = 80;
    int n_ok = 0, n_rej = 0, n_stb = 0, blen = 0, last_len = 0, k, n, s;
    logic [10:0] rw_ptr = 11'h7fe; // Next page due for rewrite
    always #25 sys_clk = ~sys_clk;
    sfct_core #(.XFR_CYC(50), .EP_CYC(400), .P_CYC(280), .PE_CYC(160),
        .BE_CYC(240)) sfct_core_i (.sys_clk, .rst, .cs_n, .sck, .si,
        .reset_n, .rd_data, .so, .so_oe, .rdy_busy_n, .cmd, .cmd_valid,
        .cmd_rejected, .page_select_bits, .byte_offset_bits, .sector,
        .rd_strobe);
    sfct_host_model sfct_host_model_i (.sys_clk, .so, .cs_n, .sck, .si);
    // Pulse counts and the length of the last busy spell
    always @(posedge sys_clk) begin
        if (cmd_valid === 1'b1) n_ok <= n_ok + 1;
        if (cmd_rejected === 1'b1) n_rej <= n_rej + 1;
        if (rd_strobe === 1'b1) n_stb <= n_stb + 1;
        blen <= (rdy_busy_n === 1'b0) ? blen + 1 : 0;
        if (rdy_busy_n === 1'b1 && blen != 0) last_len <= blen;
    end
    function automatic sfct_sector_t sec_of(input logic [10:0] p);
        if (p[10:3] == 8'h00) return 3'h0;
        if (p[10:8] == 3'h0) return 3'h1;
        if (p[10:8] == 3'h1) return 3'h2;
        return {1'b0, p[10:9]} + 3'h2;
    endfunction
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Spare high address bits always sent as zero
    task automatic send(input logic [7:0] op, input logic [10:0] p,
                        input logic [8:0] o, input logic m3, input int r);
        sfct_host_model_i.frame({op, 4'h0, p, o}, 32, m3, r, rd);
    endtask
    task automatic status();
        sfct_host_model_i.frame({24'h0, 8'hd7}, 8, 1'b1, 8, rd);
    endtask
    // Bounded wait for ready/busy to reach a level
    task automatic wait_rb(input logic lvl, input int lim);
        n = 0;
        while (rdy_busy_n !== lvl && n < lim) begin
            @(posedge sys_clk);
            n++;
        end
        #3;
        if (n >= lim) begin
            fail_count++;
            $display("Error t=%0t busy wait ran out", $time);
            stop_test();
        end
    endtask
    initial begin
        repeat (5) @(posedge sys_clk);
        #3;
        rst = 1'b0;
        `CHK({rdy_busy_n, so_oe, cmd}, {2'b10, SFCT_CMD_NONE})
        sfct_host_model_i.settle();
        k = n_ok;
        send(8'h52, 11'h0, 9'h0, 1'b0, 0);
        `CHK(n_ok, k)
        reset_n = 1'b1;
        $display("reset test done");
        for (int i = 0; i < 8; i++) begin
            pg = (i < 4) ? EPG[i] : 11'($random(seed));
            off = 9'($random(seed));
            rd_data = 8'($random(seed));
            k = n_ok;
            s = n_stb;
            send(ROP[i], pg, off, i[0], 8);
            `CHK(n_ok, k + 1)
            `CHK(cmd, RCL[i])
            `CHK({page_select_bits, byte_offset_bits}, {pg, off})
            `CHK(sector, sec_of(pg))
            `CHK(rd[7:0], rd_data)
            // One load at the answer, one reload after eight bits
            `CHK(n_stb, s + 2)
        end
        status();
        `CHK(cmd, SFCT_CMD_STATUS)
        `CHK(rd[7:0], 8'h80)
        $display("read test done");
        for (int i = 0; i < 5; i++) begin
            send(TOP[i], 11'($random(seed)), 9'h0, i[0], 0);
            `CHK(cmd, TCL[i])
            `CHK(rdy_busy_n, 1'b0)
            k = n_rej;
            if (i == 1) begin
                send(8'h52, 11'h0, 9'h0, 1'b0, 0);
                `CHK(n_rej, k + 1)
            end
            if (i == 4) begin
                status();
                `CHK(rd[7:0], 8'h00)
            end
            wait_rb(1'b1, TLIM[i] + 20);
            `CHK(last_len <= TLIM[i] && last_len + 8 >= TLIM[i], 1'b1)
        end
        // Auto page rewrite at the host's pointer, which then advances
        for (int i = 0; i < 2; i++) begin
            send(8'h58 + 8'(i), rw_ptr, 9'h0, i[0], 0);
            `CHK({cmd, page_select_bits}, {SFCT_CMD_XFR, rw_ptr})
            `CHK(sector, sec_of(rw_ptr))
            // Walking the pointer rewrites two pages in turn, from 7FEH
            rw_ptr = rw_ptr + 11'h1;
            wait_rb(1'b1, 70);
            `CHK(last_len, TLIM[0])
        end
        $display("timed test done");
        stop_test();
    end
endmodule
`default_nettype wire
